// ==== ucm_map.svh ====
// Register offsets, field positions, reset values and timing figures of the alternate-mode block
`ifndef UCM_MAP_SVH
`define UCM_MAP_SVH
`define UCM_A_FUNC       6'h04
`define UCM_A_IFC        6'h07
`define UCM_A_CARKIT     6'h19
`define UCM_A_IRQEN      6'h1d
`define UCM_A_HSA        6'h33
`define UCM_A_RID        6'h36
`define UCM_A_IOPM       6'h39
`define UCM_OP_WRITE     2'h0
`define UCM_OP_SET       2'h1
`define UCM_OP_CLEAR     2'h2
`define UCM_RST_FUNC     8'h41
`define UCM_RST_IFC      8'h00
`define UCM_RST_CARKIT   8'h00
`define UCM_RST_IRQEN    8'h00
`define UCM_RST_HSA      8'h00
`define UCM_RST_RID      8'h00
`define UCM_RST_IOPM     8'h04
`define UCM_CMD_WRITE    2'h2
`define UCM_CMD_READ     2'h3
`define UCM_FUNC_XCVR    1:0
`define UCM_IFC_CARKIT   2
`define UCM_IFC_KEEPCLK  3
`define UCM_CK_DIR2      1
`define UCM_CK_TXEN      2
`define UCM_CK_RXEN      3
`define UCM_CK_SPKL      4
`define UCM_CK_SPKR      5
`define UCM_IE_FLT_RISE  0
`define UCM_IE_FLT_FALL  1
`define UCM_IE_GND       2
`define UCM_IE_VBUS      3
`define UCM_HSA_EN       0
`define UCM_RID_VAL      2:0
`define UCM_RID_START    3
`define UCM_RID_IRQEN    4
`define UCM_IOPM_REG     1:0
`define UCM_RX_ALTINT    7
`define UCM_RX_ID        6
`define UCM_OE_CARKIT    8'hfa
`define UCM_OE_DIR2      8'h04
`define UCM_OE_HEADSET   8'h3b
`define UCM_D_TXD        0
`define UCM_D_RXD        1
`define UCM_D_INT        3
`define UCM_D_SESS       0
`define UCM_D_VBUS       1
`define UCM_D_GNDDRV     2
`define UCM_D_ID_GROUND_COMPARE      4
`define UCM_D_IDFLT      5
`define UCM_D_PU330      6
`define UCM_D_PU100      7
`define UCM_CLK_MHZ      200
`define UCM_RID_CONV_NS  1000
`endif

// ==== ucm_pkg.sv ====
// Types shared by the alternate-mode block
package ucm_pkg;
  typedef enum logic [1:0] {UCM_HS, UCM_FS, UCM_LS, UCM_FS_LS_PRE} ucm_speed_t;
  typedef struct packed {
    logic       keep_clk;
    logic       carkit_en;
    logic       headset_en;
    logic       tx_en;
    logic       rx_en;
    logic       dir2_in;
    logic       spk_l;
    logic       spk_r;
    logic [1:0] xcvr;
    logic [1:0] reg_level;
    logic [3:0] irq_en;
    logic       rid_start;
    logic       rid_irq_en;
  } ucm_cfg_t;
  typedef struct packed {
    logic id_gnd;
    logic sess;
    logic vbus;
    logic id_flt;
  } ucm_src_t;
endpackage

// ==== ucm_sync.sv ====
// Two-flop synchroniser for a bundle of levels
`timescale 1ns/100ps
module ucm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_chk
    $error("ucm_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ==== ucm_alt_mode.sv ====
// Carkit, RID converter and headset audio alternate modes of a ULPI transceiver
`timescale 1ns/100ps
`include "ucm_map.svh"
module ucm_alt_mode
  import ucm_pkg::*;
#(
  parameter int RID_CONV_NS = `UCM_RID_CONV_NS
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       ulpi_clk,
  input  wire logic       ulpi_stp,
  input  wire logic [7:0] ulpi_data_i,
  output logic      [7:0] ulpi_data_o,
  output logic      [7:0] ulpi_data_oe,
  output logic            ulpi_dir,
  output logic            ulpi_nxt,
  output logic            clkout_en,
  output logic            pll_en,
  input  wire logic       id_ground_compare,
  input  wire logic       session_valid,
  input  wire logic       bus_power_valid,
  input  wire logic       id_is_floating,
  input  wire logic       uart_dp_rx,
  input  wire logic [2:0] rid_sense_code,
  output logic            uart_dm_tx,
  output logic            uart_dm_tx_en,
  output logic            carkit_detect_pullup,
  output logic      [1:0] regulator_level,
  output logic            uart_low_speed_edges,
  output logic            audio_left_switch_en,
  output logic            audio_right_switch_en,
  output logic            id_force_ground,
  output logic            id_weak_pullup_en,
  output logic            id_pullup_en
);
  localparam int RID_CONV_CYC_I = (RID_CONV_NS * `UCM_CLK_MHZ + 999) / 1000;
  localparam int RID_CONV_CYC   = (RID_CONV_CYC_I < 1) ? 1 : RID_CONV_CYC_I;
  localparam int CW             = $clog2(RID_CONV_CYC + 1);
  localparam int NREG           = 7;
  localparam logic [5:0] BASE [NREG] = '{`UCM_A_FUNC, `UCM_A_IFC, `UCM_A_CARKIT, `UCM_A_IRQEN,
                                          `UCM_A_HSA, `UCM_A_RID, `UCM_A_IOPM};
  localparam logic [7:0] RSTV [NREG] = '{`UCM_RST_FUNC, `UCM_RST_IFC, `UCM_RST_CARKIT, `UCM_RST_IRQEN,
                                          `UCM_RST_HSA, `UCM_RST_RID, `UCM_RST_IOPM};
  localparam int R_FUNC = 0, R_IFC = 1, R_CK = 2, R_IE = 3, R_HSA = 4, R_RID = 5, R_IOPM = 6;

  if (RID_CONV_NS < 1) begin : g_chk
    $error("ucm_alt_mode: RID_CONV_NS must be positive");
  end

  typedef enum {U_IDLE, U_CMD, U_WDATA, U_RTURN, U_RDATA, U_XTURN, U_XDATA} ucm_ustate_t;
  typedef enum {C_SYNC, C_ALT, C_EXIT} ucm_cstate_t;

  // ---------------- Link clock domain: register file and synchronous protocol
  logic [7:0]  regs_q [NREG];
  ucm_ustate_t ust_q;
  logic [5:0]  addr_q;
  logic        is_read_q;
  logic [7:0]  sync_do_q;
  logic        sync_dir_q;
  logic        sync_nxt_q;
  logic        rid_pend_q;
  logic        gnd_pend_q;
  logic        gnd_prev_q;
  logic [1:0]  back_prev_q;
  logic [2:0]  back_s;
  logic        gnd_s;
  logic        exit_ev;
  logic        rid_ev;
  logic        core_alt_s;
  logic [2:0]  rid_res_q;
  logic [7:0]  rd_data;
  logic        wr_fire;

  assign exit_ev    = back_s[0] ^ back_prev_q[0];
  assign rid_ev     = back_s[1] ^ back_prev_q[1];
  assign core_alt_s = back_s[2];
  assign wr_fire    = (ust_q == U_WDATA) && sync_nxt_q && !is_read_q;

  function automatic logic [7:0] reg_update(input logic [7:0] cur, input logic [7:0] d, input logic [5:0] ofs);
    logic [7:0] r;
    r = cur;
    if (ofs == {4'h0, `UCM_OP_WRITE}) begin
      r = d;
    end else if (ofs == {4'h0, `UCM_OP_SET}) begin
      r = cur | d;
    end else if (ofs == {4'h0, `UCM_OP_CLEAR}) begin
      r = cur & ~d;
    end
    return r;
  endfunction

  always_comb begin
    rd_data = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (addr_q >= BASE[i] && addr_q <= BASE[i] + 6'h02 && (i != R_HSA || addr_q == BASE[i])) begin
        rd_data = regs_q[i];
      end
    end
  end

  always_ff @(posedge ulpi_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= RSTV[i];
      end
    end else begin
      if (exit_ev) begin
        regs_q[R_IFC][`UCM_IFC_CARKIT] <= 1'b0;
        regs_q[R_HSA][`UCM_HSA_EN]     <= 1'b0;
      end
      if (rid_ev) begin
        regs_q[R_RID][`UCM_RID_START] <= 1'b0;
      end
      if (wr_fire) begin
        for (int i = 0; i < NREG; i++) begin
          if (addr_q >= BASE[i] && addr_q <= BASE[i] + 6'h02 && (i != R_HSA || addr_q == BASE[i])) begin
            regs_q[i] <= reg_update(regs_q[i], ulpi_data_i, addr_q - BASE[i]);
          end
        end
      end
      regs_q[R_RID][`UCM_RID_VAL] <= rid_ev ? rid_res_q : regs_q[R_RID][`UCM_RID_VAL];
    end
  end

  always_ff @(posedge ulpi_clk or negedge rstn) begin
    if (!rstn) begin
      back_prev_q <= 2'h0;
      // Same level as the synchroniser's reset, so its release never looks like a fall
      gnd_prev_q  <= 1'b0;
    end else begin
      back_prev_q <= back_s[1:0];
      gnd_prev_q  <= gnd_s;
    end
  end

  // Set wins over the clear that sending an RXCMD makes
  always_ff @(posedge ulpi_clk or negedge rstn) begin
    if (!rstn) begin
      rid_pend_q <= 1'b0;
      gnd_pend_q <= 1'b0;
    end else begin
      if (rid_ev && regs_q[R_RID][`UCM_RID_IRQEN]) begin
        rid_pend_q <= 1'b1;
      end else if (ust_q == U_XDATA) begin
        rid_pend_q <= 1'b0;
      end
      if (gnd_prev_q && !gnd_s && !core_alt_s) begin
        gnd_pend_q <= 1'b1;
      end else if (ust_q == U_XDATA) begin
        gnd_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ulpi_clk or negedge rstn) begin
    if (!rstn) begin
      ust_q      <= U_IDLE;
      addr_q     <= 6'h00;
      is_read_q  <= 1'b0;
      sync_do_q  <= 8'h00;
      sync_dir_q <= 1'b0;
      sync_nxt_q <= 1'b0;
    end else begin
      case (ust_q)
        U_IDLE: begin
          sync_nxt_q <= 1'b0;
          sync_dir_q <= 1'b0;
          if (core_alt_s) begin
            ust_q <= U_IDLE;
          end else if (ulpi_data_i[7:6] == `UCM_CMD_WRITE || ulpi_data_i[7:6] == `UCM_CMD_READ) begin
            addr_q     <= ulpi_data_i[5:0];
            is_read_q  <= ulpi_data_i[6];
            sync_nxt_q <= 1'b1;
            ust_q      <= U_CMD;
          end else if (rid_pend_q || gnd_pend_q) begin
            sync_dir_q <= 1'b1;
            ust_q      <= U_XTURN;
          end
        end
        U_CMD: begin
          sync_nxt_q <= !is_read_q;
          sync_dir_q <= is_read_q;
          ust_q      <= is_read_q ? U_RTURN : U_WDATA;
        end
        U_WDATA: begin
          sync_nxt_q <= 1'b0;
          if (ulpi_stp) begin
            ust_q <= U_IDLE;
          end
        end
        U_RTURN: begin
          sync_do_q <= rd_data;
          ust_q     <= U_RDATA;
        end
        U_RDATA: begin
          sync_dir_q <= 1'b0;
          ust_q      <= U_IDLE;
        end
        U_XTURN: begin
          sync_do_q                <= 8'h00;
          sync_do_q[`UCM_RX_ALTINT] <= rid_pend_q;
          sync_do_q[`UCM_RX_ID]     <= gnd_s;
          ust_q                    <= U_XDATA;
        end
        U_XDATA: begin
          sync_dir_q <= 1'b0;
          ust_q      <= U_IDLE;
        end
        default: begin
          ust_q <= U_IDLE;
        end
      endcase
    end
  end

  ucm_cfg_t cfg_l;
  always_comb begin
    cfg_l            = '0;
    cfg_l.keep_clk   = regs_q[R_IFC][`UCM_IFC_KEEPCLK];
    cfg_l.carkit_en  = regs_q[R_IFC][`UCM_IFC_CARKIT];
    cfg_l.headset_en = regs_q[R_HSA][`UCM_HSA_EN];
    cfg_l.tx_en      = regs_q[R_CK][`UCM_CK_TXEN];
    cfg_l.rx_en      = regs_q[R_CK][`UCM_CK_RXEN];
    cfg_l.dir2_in    = regs_q[R_CK][`UCM_CK_DIR2];
    cfg_l.spk_l      = regs_q[R_CK][`UCM_CK_SPKL];
    cfg_l.spk_r      = regs_q[R_CK][`UCM_CK_SPKR];
    cfg_l.xcvr       = regs_q[R_FUNC][`UCM_FUNC_XCVR];
    cfg_l.reg_level  = regs_q[R_IOPM][`UCM_IOPM_REG];
    cfg_l.irq_en     = regs_q[R_IE][3:0];
    cfg_l.rid_start  = regs_q[R_RID][`UCM_RID_START];
    cfg_l.rid_irq_en = regs_q[R_RID][`UCM_RID_IRQEN];
  end

  // ---------------- Core clock domain: mode sequencing and redefined pins
  ucm_cfg_t    cfg_s;
  ucm_src_t    src_raw;
  ucm_src_t    src_s;
  ucm_src_t    snap_q;
  ucm_cstate_t cst_q;
  logic        headset_q;
  logic        armed_q;
  logic        keep_q;
  logic        alt_dir_q;
  logic [7:0]  alt_do_q;
  logic [7:0]  alt_oe_q;
  logic [7:0]  din_s;
  logic        stp_s;
  logic        dp_s;
  logic [2:0]  code_s;
  logic        exit_tgl_q;
  logic        rid_tgl_q;
  logic        rid_busy_q;
  logic        rid_start_prev_q;
  logic [CW-1:0] rid_cnt_q;
  logic        alt_irq;
  logic        entry_req;
  ucm_speed_t  speed;

  assign src_raw = '{id_gnd: id_ground_compare, sess: session_valid, vbus: bus_power_valid,
                     id_flt: id_is_floating};
  assign speed   = ucm_speed_t'(cfg_s.xcvr);

  ucm_sync #(.WIDTH($bits(ucm_cfg_t))) u_cfg_sync (
    .clock (clock),
    .rstn  (rstn),
    .d     (cfg_l),
    .q     (cfg_s)
  );
  ucm_sync #(.WIDTH(13 + $bits(ucm_src_t))) u_pin_sync (
    .clock (clock),
    .rstn  (rstn),
    .d     ({ulpi_data_i, ulpi_stp, uart_dp_rx, rid_sense_code, src_raw}),
    .q     ({din_s, stp_s, dp_s, code_s, src_s})
  );
  ucm_sync #(.WIDTH(3)) u_back_sync (
    .clock (ulpi_clk),
    .rstn  (rstn),
    .d     ({cst_q != C_SYNC, rid_tgl_q, exit_tgl_q}),
    .q     (back_s)
  );
  ucm_sync #(.WIDTH(1)) u_gnd_sync (
    .clock (ulpi_clk),
    .rstn  (rstn),
    .d     (id_ground_compare),
    .q     (gnd_s)
  );

  always_comb begin
    alt_irq = (cfg_s.irq_en[`UCM_IE_FLT_RISE] && src_s.id_flt && !snap_q.id_flt)
           || (cfg_s.irq_en[`UCM_IE_FLT_FALL] && !src_s.id_flt && snap_q.id_flt)
           || (cfg_s.irq_en[`UCM_IE_VBUS] && (src_s.vbus != snap_q.vbus))
           || (cfg_s.irq_en[`UCM_IE_GND] && (src_s.id_gnd != snap_q.id_gnd))
           || (snap_q.id_gnd && !src_s.id_gnd);
  end

  // Entry needs the mode bit seen low once since the last exit, so a stale bit cannot re-enter
  assign entry_req = armed_q && (cfg_s.carkit_en || cfg_s.headset_en);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      armed_q <= 1'b1;
    end else if (cst_q == C_EXIT) begin
      armed_q <= 1'b0;
    end else if (!cfg_s.carkit_en && !cfg_s.headset_en) begin
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cst_q      <= C_SYNC;
      headset_q  <= 1'b0;
      keep_q     <= 1'b0;
      snap_q     <= '0;
      alt_dir_q  <= 1'b0;
      exit_tgl_q <= 1'b0;
    end else begin
      case (cst_q)
        C_SYNC: begin
          if (entry_req && !stp_s) begin
            snap_q    <= src_s;
            headset_q <= cfg_s.headset_en;
            keep_q    <= cfg_s.keep_clk;
            alt_dir_q <= 1'b1;
            cst_q     <= C_ALT;
          end
        end
        C_ALT: begin
          if (stp_s) begin
            alt_dir_q <= 1'b0;
            cst_q     <= C_EXIT;
          end
        end
        C_EXIT: begin
          if (!stp_s) begin
            exit_tgl_q <= !exit_tgl_q;
            keep_q     <= 1'b0;
            cst_q      <= C_SYNC;
          end
        end
        default: begin
          cst_q <= C_SYNC;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      alt_do_q <= 8'h00;
      alt_oe_q <= 8'h00;
    end else if (headset_q) begin
      alt_do_q                <= 8'h00;
      alt_do_q[`UCM_D_SESS]   <= src_s.sess;
      alt_do_q[`UCM_D_VBUS]   <= src_s.vbus && cfg_s.irq_en[`UCM_IE_VBUS];
      alt_do_q[`UCM_D_ID_GROUND_COMPARE]  <= src_s.id_gnd;
      alt_do_q[`UCM_D_IDFLT]  <= src_s.id_flt;
      alt_oe_q                <= `UCM_OE_HEADSET;
    end else begin
      alt_do_q                <= 8'h00;
      alt_do_q[`UCM_D_INT]    <= alt_irq;
      alt_do_q[`UCM_D_RXD]    <= dp_s && cfg_s.rx_en;
      alt_oe_q                <= cfg_s.dir2_in ? `UCM_OE_CARKIT : (`UCM_OE_CARKIT | `UCM_OE_DIR2);
    end
  end

  // Measurement runs on the core clock so it completes even while the link clock is stopped
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rid_busy_q       <= 1'b0;
      rid_cnt_q        <= '0;
      rid_tgl_q        <= 1'b0;
      rid_res_q        <= 3'h0;
      rid_start_prev_q <= 1'b0;
    end else begin
      rid_start_prev_q <= cfg_s.rid_start;
      if (!rid_busy_q && cfg_s.rid_start && !rid_start_prev_q) begin
        rid_busy_q <= 1'b1;
        rid_cnt_q  <= CW'(RID_CONV_CYC);
      end else if (rid_busy_q && rid_cnt_q == CW'(1)) begin
        rid_busy_q <= 1'b0;
        rid_cnt_q  <= '0;
        rid_res_q  <= code_s;
        rid_tgl_q  <= !rid_tgl_q;
      end else if (rid_busy_q) begin
        rid_cnt_q  <= rid_cnt_q - CW'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      clkout_en             <= 1'b1;
      pll_en                <= 1'b1;
      uart_dm_tx            <= 1'b1;
      uart_dm_tx_en         <= 1'b0;
      carkit_detect_pullup  <= 1'b0;
      regulator_level       <= 2'h0;
      uart_low_speed_edges  <= 1'b0;
      audio_left_switch_en  <= 1'b0;
      audio_right_switch_en <= 1'b0;
      id_force_ground       <= 1'b0;
      id_weak_pullup_en     <= 1'b0;
      id_pullup_en          <= 1'b0;
    end else begin
      clkout_en             <= (cst_q == C_SYNC) || keep_q;
      pll_en                <= (cst_q == C_SYNC) || keep_q;
      uart_dm_tx            <= din_s[`UCM_D_TXD];
      uart_dm_tx_en         <= (cst_q != C_SYNC) && !headset_q && cfg_s.tx_en;
      carkit_detect_pullup  <= (cst_q != C_SYNC) && !headset_q && (cfg_s.tx_en || cfg_s.rx_en);
      regulator_level       <= cfg_s.reg_level;
      uart_low_speed_edges  <= (speed == UCM_LS);
      audio_left_switch_en  <= cfg_s.spk_l;
      audio_right_switch_en <= cfg_s.spk_r;
      id_force_ground       <= (cst_q == C_ALT) && headset_q && din_s[`UCM_D_GNDDRV];
      id_weak_pullup_en     <= (cst_q == C_ALT) && headset_q && din_s[`UCM_D_PU330];
      id_pullup_en          <= (cst_q == C_ALT) && headset_q && din_s[`UCM_D_PU100];
    end
  end

  // Pin ownership moves to the core domain while an alternate mode holds the bus
  assign ulpi_dir     = (cst_q != C_SYNC) ? alt_dir_q : sync_dir_q;
  assign ulpi_nxt     = (cst_q != C_SYNC) ? 1'b0 : sync_nxt_q;
  assign ulpi_data_o  = (cst_q == C_ALT) ? alt_do_q : sync_do_q;
  assign ulpi_data_oe = (cst_q == C_ALT) ? alt_oe_q : (sync_dir_q ? 8'hff : 8'h00);
endmodule

// ==== ucm_link.sv ====
// Link-side model: register commands and pin drive on the ULPI bus
`timescale 1ns/100ps
module ucm_link (
  input  wire logic       ulpi_clk,
  input  wire logic       ulpi_dir,
  input  wire logic [7:0] ulpi_data_o,
  input  wire logic [7:0] ulpi_data_oe,
  output logic            ulpi_stp,
  output logic      [7:0] ulpi_data_i
);
  logic [7:0] drv_q;
  logic       own;
  initial begin
    ulpi_stp = 1'b1;
    drv_q    = 8'h00;
  end
  // Released bits carry the link's drive value drv_q, never fall to the weak pull-downs
  assign own         = !(ulpi_dir && ulpi_data_oe == 8'hff);
  assign ulpi_data_i = (ulpi_data_oe & ulpi_data_o) | (~ulpi_data_oe & (own ? drv_q : 8'h00));
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge ulpi_clk);
    drv_q <= {2'b10, a};
    @(posedge ulpi_clk);
    drv_q <= v;
    // Next stands two cycles; the data byte is taken at the end of the second
    repeat (2) @(posedge ulpi_clk);
    drv_q    <= 8'h00;
    ulpi_stp <= 1'b1;
    @(posedge ulpi_clk);
    ulpi_stp <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge ulpi_clk);
    drv_q <= {2'b11, a};
    @(posedge ulpi_clk);
    drv_q <= 8'h00;
    repeat (3) @(posedge ulpi_clk);
    v = ulpi_data_i;
  endtask
  task automatic pins(input logic [7:0] v);
    @(posedge ulpi_clk);
    drv_q <= v;
  endtask
  // stop raised to leave, dropped after direction falls
  task automatic stop(input logic v);
    @(posedge ulpi_clk);
    ulpi_stp <= v;
  endtask
endmodule

// ==== ucm_alt_mode_assertions.sv ====
// Concurrent checks on the alternate-mode block ports
`timescale 1ns/100ps
module ucm_alt_chk (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       ulpi_stp,
  input wire logic [7:0] ulpi_data_i,
  input wire logic [7:0] ulpi_data_o,
  input wire logic [7:0] ulpi_data_oe,
  input wire logic       ulpi_dir,
  input wire logic       ulpi_nxt,
  input wire logic       clkout_en,
  input wire logic       pll_en,
  input wire logic       session_valid,
  input wire logic       id_ground_compare,
  input wire logic       uart_dm_tx,
  input wire logic       uart_dm_tx_en,
  input wire logic       id_force_ground
);
  logic ck;
  logic hs;
  // Modes told apart by enable pattern; bit 2 may go either way in carkit
  assign ck = ulpi_dir && ((ulpi_data_oe & 8'hfb) == 8'hfa);
  assign hs = ulpi_dir && (ulpi_data_oe == 8'h3b);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_carkit_upper_low: assert property (ck |-> ulpi_data_o[7:4] == 4'h0)
    else $error("upper bits high in carkit");
  a_dir2_drive_low: assert property (ck && ulpi_data_oe[2] |-> !ulpi_data_o[2])
    else $error("bit 2 driven high");
  a_alt_nxt_low: assert property (ck || hs |-> !ulpi_nxt)
    else $error("next high in alternate mode");
  a_pll_with_clk: assert property ((!ulpi_dir && !ulpi_stp)[*6] |-> clkout_en && pll_en)
    else $error("clock or pll off in synchronous mode");
  a_stp_exit_dir: assert property ((ck || hs) && ulpi_stp |-> ##[1:6] !ulpi_dir)
    else $error("direction held after stop");
  a_hs_bit3_low: assert property (hs |-> !ulpi_data_o[3])
    else $error("bit 3 high in headset mode");
  a_hs_sess_shown: assert property ((hs && session_valid)[*5] |-> ulpi_data_o[0])
    else $error("session level not shown");
  a_hs_id_ground_compare_shown: assert property ((hs && id_ground_compare)[*5] |-> ulpi_data_o[4])
    else $error("id level not shown");
  a_uart_tx_follow: assert property ((ck && uart_dm_tx_en && !ulpi_data_i[0])[*5] |-> !uart_dm_tx)
    else $error("transmit pin not following");
  a_id_gnd_drive: assert property ((hs && ulpi_data_i[2])[*5] |-> id_force_ground)
    else $error("id ground drive missing");
endmodule
bind ucm_alt_mode ucm_alt_chk ucm_alt_chk_inst (.clock, .rstn, .ulpi_stp, .ulpi_data_i, .ulpi_data_o,
  .ulpi_data_oe, .ulpi_dir, .ulpi_nxt, .clkout_en, .pll_en, .session_valid, .id_ground_compare, .uart_dm_tx,
  .uart_dm_tx_en, .id_force_ground);

// ==== tb.sv ====
// Testbench for the alternate-mode block
`timescale 1ns/100ps
module tb;
  logic       clock    = 1'b0;
  logic       ulpi_clk = 1'b0;
  logic       rstn, id_ground_compare, session_valid, bus_power_valid, id_is_floating, uart_dp_rx;
  logic [2:0] rid_sense_code;
  logic [7:0] ulpi_data_i, ulpi_data_o, ulpi_data_oe;
  logic       ulpi_stp, ulpi_dir, ulpi_nxt, clkout_en, pll_en, uart_dm_tx, uart_dm_tx_en, carkit_detect_pullup;
  logic [1:0] regulator_level;
  logic       uart_low_speed_edges, audio_left_switch_en, audio_right_switch_en;
  logic       id_force_ground, id_weak_pullup_en, id_pullup_en;
  int         failures  = 0;
  int         cmp_count = 0;
  logic [5:0] regs [5] = '{6'h04, 6'h07, 6'h19, 6'h39, 6'h3c};
  logic [7:0] dflt [5] = '{8'h41, 8'h00, 8'h00, 8'h04, 8'h00};
  always #2.5 clock = ~clock;
  always #3 ulpi_clk = ~ulpi_clk;
  ucm_alt_mode #(.RID_CONV_NS(50)) ucm_alt_mode_inst (
    .clock, .rstn, .ulpi_clk, .ulpi_stp, .ulpi_data_i, .ulpi_data_o, .ulpi_data_oe, .ulpi_dir, .ulpi_nxt,
    .clkout_en, .pll_en, .id_ground_compare, .session_valid, .bus_power_valid, .id_is_floating, .uart_dp_rx,
    .rid_sense_code, .uart_dm_tx, .uart_dm_tx_en, .carkit_detect_pullup, .regulator_level, .uart_low_speed_edges,
    .audio_left_switch_en, .audio_right_switch_en, .id_force_ground, .id_weak_pullup_en, .id_pullup_en);
  ucm_link ucm_link_inst (.ulpi_clk, .ulpi_dir, .ulpi_data_o, .ulpi_data_oe, .ulpi_stp, .ulpi_data_i);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle;
    repeat (20) @(posedge clock);
  endtask
  task automatic wait_dir(input logic v);
    for (int i = 0; i < 200 && ulpi_dir !== v; i++) @(posedge clock);
    chk(ulpi_dir, v);
  endtask
  // Status byte is sampled in the cycle after direction turns
  task automatic rxcmd(input logic [7:0] m, input logic [7:0] e);
    for (int i = 0; i < 400 && ulpi_dir !== 1'b1; i++) @(posedge ulpi_clk);
    chk(ulpi_dir, 1'b1);
    @(posedge ulpi_clk);
    chk(ulpi_data_o & m, e);
  endtask
  task automatic exit_alt;
    ucm_link_inst.stop(1'b1);
    wait_dir(1'b0);
    ucm_link_inst.pins(8'h00);
    ucm_link_inst.stop(1'b0);
    settle;
  endtask
  task automatic t_defaults;
    logic [7:0] r;
    foreach (regs[i]) begin
      ucm_link_inst.rd(regs[i], r);
      chk(r, dflt[i]);
    end
    chk(clkout_en, 1'b1);
  endtask
  task automatic t_audio;
    logic [7:0] r;
    ucm_link_inst.wr(6'h19, 8'h30);
    settle;
    chk({audio_left_switch_en, audio_right_switch_en}, 2'b11);
    ucm_link_inst.wr(6'h1b, 8'h10);
    settle;
    chk({audio_left_switch_en, audio_right_switch_en}, 2'b01);
    ucm_link_inst.rd(6'h19, r);
    chk(r, 8'h20);
  endtask
  task automatic t_uart;
    ucm_link_inst.wr(6'h39, 8'h03);
    for (int x = 0; x < 4; x++) begin
      ucm_link_inst.wr(6'h04, 8'h48 | 8'(x));
      settle;
      chk(uart_low_speed_edges, x == 2);
    end
    ucm_link_inst.wr(6'h04, 8'h49);
    ucm_link_inst.wr(6'h39, 8'h00);
    ucm_link_inst.wr(6'h19, 8'h0c);
    ucm_link_inst.wr(6'h07, 8'h04);
    wait_dir(1'b1);
    @(posedge clock) uart_dp_rx <= 1'b1;
    settle;
    chk({clkout_en, pll_en}, 2'b00);
    chk({carkit_detect_pullup, regulator_level}, 3'b100);
    chk(uart_dm_tx_en, 1'b1);
    chk(uart_dm_tx, 1'b0);
    chk(ulpi_data_o & ulpi_data_oe, 8'h02);
    chk(ulpi_data_oe, 8'hfe);
    ucm_link_inst.pins(8'h01);
    settle;
    chk(uart_dm_tx, 1'b1);
    exit_alt;
  endtask
  task automatic t_keep;
    logic [7:0] r;
    ucm_link_inst.wr(6'h07, 8'h08);
    ucm_link_inst.wr(6'h1a, 8'h02);
    ucm_link_inst.wr(6'h08, 8'h04);
    wait_dir(1'b1);
    @(posedge clock) id_is_floating <= 1'b1;
    settle;
    chk(clkout_en, 1'b1);
    chk(ulpi_data_oe, 8'hfa);
    chk(ulpi_data_o[3], 1'b0);
    @(posedge clock) id_ground_compare <= 1'b0;
    settle;
    chk(ulpi_data_o[3], 1'b1);
    @(posedge clock) id_ground_compare <= 1'b1;
    exit_alt;
    ucm_link_inst.rd(6'h07, r);
    chk(r, 8'h08);
  endtask
  task automatic t_rid;
    logic [7:0] r;
    @(posedge clock) rid_sense_code <= 3'h5;
    ucm_link_inst.wr(6'h36, 8'h18);
    rxcmd(8'h80, 8'h80);
    ucm_link_inst.rd(6'h36, r);
    chk(r, 8'h15);
    @(posedge clock) id_ground_compare <= 1'b0;
    rxcmd(8'h40, 8'h00);
    @(posedge clock) id_ground_compare <= 1'b1;
    settle;
  endtask
  task automatic t_headset;
    logic [7:0] r;
    ucm_link_inst.wr(6'h1d, 8'h08);
    @(posedge clock) {session_valid, bus_power_valid} <= 2'b11;
    ucm_link_inst.wr(6'h33, 8'h01);
    wait_dir(1'b1);
    ucm_link_inst.pins(8'h44);
    settle;
    chk(ulpi_data_o & ulpi_data_oe, 8'h33);
    chk({id_force_ground, id_weak_pullup_en, id_pullup_en}, 3'b110);
    ucm_link_inst.pins(8'h00);
    @(posedge clock) rstn <= 1'b0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    settle;
    chk(ulpi_dir, 1'b0);
    ucm_link_inst.rd(6'h33, r);
    chk(r, 8'h00);
  endtask
  task automatic summarize;
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    rstn              <= 1'b0;
    id_ground_compare <= 1'b1;
    {session_valid, bus_power_valid, id_is_floating, uart_dp_rx} <= 4'h0;
    rid_sense_code    <= 3'h0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    ucm_link_inst.stop(1'b0);
    t_defaults;
    t_audio;
    t_uart;
    t_keep;
    t_rid;
    t_headset;
    summarize;
  end
  initial begin
    #200000;
    failures++;
    summarize;
  end
endmodule
